//--- src/dps_pkg.sv
// ============================================================
// Shared constants of the quad digipot serial control block
package dps_pkg;

  // ============================================================
  // Array geometry
  localparam int NUM_POTS      = 4;
  localparam int SLOTS_PER_POT = 4;
  localparam int TAP_W         = 8;
  localparam int NUM_TAPS      = 256;   // Both array ends are taps
  localparam int NUM_ELEMENTS  = 255;   // Series resistors between taps
  localparam int STORE_IDX_W   = 4;     // {pot, slot}

  // ============================================================
  // Values after reset and limits
  localparam logic [7:0] STORED_ERASED = 8'h00;  // Content before first write
  localparam logic [7:0] WIPER_MIN     = 8'h00;  // Low end terminal tap
  localparam logic [7:0] WIPER_MAX     = 8'hFF;  // High end terminal tap
  localparam logic [1:0] BOOT_SLOT     = 2'h0;
  localparam logic [3:0] BIT_ACK       = 4'h8;   // Ninth clock of a byte

  // ============================================================
  // Frame layout: address byte {DEV_TYPE, straps, r/w}
  localparam logic [2:0] DEV_TYPE      = 3'h2;
  localparam int         ADDR_TYPE_LSB = 5;
  localparam int         ADDR_STRAP_LSB = 1;
  // Instruction byte {opcode[7:4], pot[3:2], slot[1:0]}
  localparam int         OP_LSB        = 4;

  // ============================================================
  // Instruction opcodes
  localparam logic [3:0] OP_RD_WIPER   = 4'h9;
  localparam logic [3:0] OP_WR_WIPER   = 4'hA;
  localparam logic [3:0] OP_RD_STORED  = 4'hB;
  localparam logic [3:0] OP_WR_STORED  = 4'hC;
  localparam logic [3:0] OP_RECALL     = 4'hD;  // Stored slot to wiper
  localparam logic [3:0] OP_SAVE       = 4'hE;  // Wiper to stored slot
  localparam logic [3:0] OP_STEP       = 4'h2;  // Increment/decrement mode

  // ============================================================
  // Serial engine states
  typedef enum logic [8:0] {
    ST_BOOT  = 9'h001,
    ST_IDLE  = 9'h002,
    ST_ADDR  = 9'h004,
    ST_INSTR = 9'h008,
    ST_WRITE = 9'h010,
    ST_READ  = 9'h020,
    ST_STEP  = 9'h040,
    ST_SKIP  = 9'h080,
    ST_WAIT  = 9'h100
  } dps_state_t;

endpackage : dps_pkg

//--- src/dps_sync.sv
`timescale 1ns/1ps
// ============================================================
// Two-flop synchroniser for pins from outside the clock domain
module dps_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // ============================================================
  // Elaboration check
  if (WIDTH < 1) begin : g_bad_width
    $error("dps_sync needs WIDTH of at least one");
  end

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule : dps_sync

//--- src/dps_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - Each of four pots has its own 8-bit wiper position register
// - Exactly one of 256 taps is selected per pot, by that register
// - 255 series elements; value zero is low end, maximum is high end
// - Four 8-bit retained stored settings per pot, sixteen in all
// - After power-up each wiper loads its first stored setting automatically
// - Write guard low blocks stored writes; wiper writes still succeed
// - Write guard high or floating allows every read and write
// - Only respond when the address matches the four strap inputs
// - Serial data is open drain: pull low or release only
// - Master supplies serial clock; all shifting follows that clock only
// - Wiper and stored registers are readable and writable over the bus
// - Instructions copy wiper to any own slot and any own slot to wiper
// - Step mode moves the selected wiper one tap per bit
module dps_ctrl (
  input  wire logic                                         sys_clk,
  input  wire logic                                         rstn,
  input  wire logic                                         scl,
  input  wire logic                                         sda_in,
  output logic                                              sda_out,
  output logic                                              sda_oe,
  input  wire logic                                         write_guard_n,
  input  wire logic                                         addr_strap_bit0,
  input  wire logic                                         addr_strap_bit1,
  input  wire logic                                         addr_strap_bit2,
  input  wire logic                                         addr_strap_bit3,
  output logic [dps_pkg::NUM_POTS-1:0][dps_pkg::TAP_W-1:0]  wiper_position,
  output logic [dps_pkg::NUM_POTS-1:0][dps_pkg::NUM_TAPS-1:0] tap_sel
);
  import dps_pkg::*;

  // ============================================================
  // Pin synchronisation
  logic [6:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       guard_s;
  logic [3:0] strap_s;

  dps_sync #(.WIDTH(7)) u_sync (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .async_in ({write_guard_n, addr_strap_bit3, addr_strap_bit2,
                addr_strap_bit1, addr_strap_bit0, sda_in, scl}),
    .sync_out (pins_s)
  );

  assign scl_s   = pins_s[0];
  assign sda_s   = pins_s[1];
  assign strap_s = pins_s[5:2];
  assign guard_s = pins_s[6];

  // ============================================================
  // State
  dps_state_t                      state_reg,  state_next;
  logic [3:0]                      cnt_reg,    cnt_next;
  logic                            acked_reg,  acked_next;
  logic [7:0]                      shift_reg,  shift_next;
  logic [7:0]                      out_reg,    out_next;
  logic [3:0]                      op_reg,     op_next;
  logic [STORE_IDX_W-1:0]          idx_reg,    idx_next;
  logic                            oe_reg,     oe_next;
  logic                            scl_d_reg;
  logic                            sda_d_reg;
  logic [NUM_POTS-1:0][TAP_W-1:0]  wiper_reg,  wiper_next;
  // Retained across rstn; only power sets the erased value
  logic [15:0][7:0]                stored_reg = {16{STORED_ERASED}};
  logic                            st_we;
  logic [STORE_IDX_W-1:0]          st_idx;
  logic [7:0]                      st_wdata;
  logic                            scl_rise;
  logic                            scl_fall;
  logic                            start_cond;
  logic                            stop_cond;
  logic                            nv_ok;

  // Saturating one-tap move; never wraps past an end
  function automatic logic [7:0] dps_step(input logic [7:0] v, input logic up);
    logic [7:0] r;
    r = v;
    if (up && v != WIPER_MAX) begin
      r = v + 8'h01;
    end else if (!up && v != WIPER_MIN) begin
      r = v - 8'h01;
    end
    return r;
  endfunction : dps_step

  // Bus edges seen from synchronised levels only
  assign scl_rise   = scl_s & ~scl_d_reg;
  assign scl_fall   = ~scl_s & scl_d_reg;
  assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  // Floating guard pin is expected to be pulled high on the board
  assign nv_ok      = guard_s;

  // ============================================================
  // Serial engine next state
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    acked_next = acked_reg;
    shift_next = shift_reg;
    out_next   = out_reg;
    op_next    = op_reg;
    idx_next   = idx_reg;
    oe_next    = oe_reg;
    wiper_next = wiper_reg;
    st_we      = 1'b0;
    st_idx     = idx_reg;
    st_wdata   = wiper_reg[idx_reg[3:2]];
    if (state_reg == ST_BOOT) begin
      // One cycle after reset release, recall slot zero of each pot
      for (int i = 0; i < NUM_POTS; i++) begin
        wiper_next[i] = stored_reg[{2'(i), BOOT_SLOT}];
      end
      state_next = ST_IDLE;
    end else if (start_cond) begin
      state_next = ST_ADDR;
      cnt_next   = 4'h0;
      acked_next = 1'b0;
      oe_next    = 1'b0;
    end else if (stop_cond) begin
      state_next = ST_IDLE;
      oe_next    = 1'b0;
    end else if (state_reg == ST_IDLE || state_reg == ST_SKIP) begin
      oe_next    = 1'b0;
    end else if (scl_rise) begin
      // Ack clock of the step instruction is no step bit: our own ack
      // still holds the line low and would read as a step down
      if (state_reg == ST_STEP && cnt_reg != BIT_ACK) begin
        // Data bit high steps up, low steps down
        wiper_next[idx_reg[3:2]] = dps_step(wiper_reg[idx_reg[3:2]], sda_s);
      end else if (cnt_reg == BIT_ACK) begin
        cnt_next   = 4'h0;
        acked_next = 1'b0;
      end else begin
        shift_next = {shift_reg[6:0], sda_s};
        cnt_next   = cnt_reg + 4'h1;
      end
    end else if (scl_fall) begin
      if (state_reg == ST_STEP) begin
        oe_next = 1'b0;
      end else if (cnt_reg == BIT_ACK && !acked_reg) begin
        // Byte complete: act on it and pull low to acknowledge
        acked_next = 1'b1;
        oe_next    = 1'b1;
        case (state_reg)
          ST_ADDR: begin
            if (shift_reg[7:ADDR_TYPE_LSB] == DEV_TYPE &&
                shift_reg[ADDR_STRAP_LSB+:4] == strap_s) begin
              state_next = ST_INSTR;
            end else begin
              state_next = ST_SKIP;
              oe_next    = 1'b0;
            end
          end
          ST_INSTR: begin
            op_next  = shift_reg[7:OP_LSB];
            idx_next = shift_reg[3:0];
            st_idx   = shift_reg[3:0];
            st_wdata = wiper_reg[shift_reg[3:2]];
            case (shift_reg[7:OP_LSB])
              OP_RD_WIPER: begin
                out_next   = wiper_reg[shift_reg[3:2]];
                state_next = ST_READ;
              end
              OP_RD_STORED: begin
                out_next   = stored_reg[shift_reg[3:0]];
                state_next = ST_READ;
              end
              OP_WR_WIPER, OP_WR_STORED: begin
                state_next = ST_WRITE;
              end
              OP_RECALL: begin
                wiper_next[shift_reg[3:2]] = stored_reg[shift_reg[3:0]];
                state_next = ST_WAIT;
              end
              OP_SAVE: begin
                st_we      = nv_ok;
                state_next = ST_WAIT;
              end
              OP_STEP: begin
                state_next = ST_STEP;
              end
              default: begin
                oe_next    = 1'b0;                                 // Unknown op is not acked
                state_next = ST_WAIT;
              end
            endcase
          end
          ST_WRITE: begin
            if (op_reg == OP_WR_WIPER) begin
              wiper_next[idx_reg[3:2]] = shift_reg;
            end else begin
              st_wdata = shift_reg;
              st_we    = nv_ok;
            end
            state_next = ST_WAIT;
          end
          default: begin
            // Read byte: the master answers, we release
            oe_next    = 1'b0;
            state_next = ST_WAIT;
          end
        endcase
      end else if (cnt_reg != BIT_ACK) begin
        // Data bits change only while the clock is low
        oe_next = (state_reg == ST_READ) ? ~out_reg[3'(4'h7 - cnt_reg)] : 1'b0;
      end
    end
  end

  // ============================================================
  // Serial engine registers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_reg <= ST_BOOT;
      cnt_reg   <= 4'h0;
      acked_reg <= 1'b0;
      shift_reg <= 8'h00;
      out_reg   <= 8'h00;
      op_reg    <= 4'h0;
      idx_reg   <= 4'h0;
      oe_reg    <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      wiper_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      acked_reg <= acked_next;
      shift_reg <= shift_next;
      out_reg   <= out_next;
      op_reg    <= op_next;
      idx_reg   <= idx_next;
      oe_reg    <= oe_next;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      wiper_reg <= wiper_next;
    end
  end

  // Stored settings; no reset so values survive rstn
  always_ff @(posedge sys_clk) begin
    if (st_we) begin
      stored_reg[st_idx] <= st_wdata;
    end
  end

  // ============================================================
  // Tap decode: one select per pot, tap 0 is the low end terminal
  always_comb begin
    tap_sel = '0;
    for (int i = 0; i < NUM_POTS; i++) begin
      tap_sel[i][wiper_reg[i]] = 1'b1;
    end
  end

  assign wiper_position = wiper_reg;
  assign sda_out        = 1'b0;
  assign sda_oe         = oe_reg;

  // ============================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  tap_onehot_a: assert property ($onehot(tap_sel[0]) && $onehot(tap_sel[1]) &&
      $onehot(tap_sel[2]) && $onehot(tap_sel[3]))
    else $error("tap select not one-hot");
  tap_match_a: assert property (tap_sel[3][wiper_position[3]] &&
      tap_sel[0][wiper_position[0]])
    else $error("selected tap differs from wiper value");
  boot_copy_a: assert property (state_reg == ST_BOOT |=>
      wiper_reg[0] == stored_reg[0] && wiper_reg[3] == stored_reg[12])
    else $error("boot recall missed slot zero");
  guard_block_a: assert property (!nv_ok |=> $stable(stored_reg))
    else $error("stored setting changed while guarded");
  guard_open_a: assert property (nv_ok && st_we |=>
      stored_reg[$past(st_idx)] == $past(st_wdata))
    else $error("stored write lost while unguarded");
  addr_miss_a: assert property (state_reg == ST_ADDR && scl_fall &&
      cnt_reg == BIT_ACK && !acked_reg &&
      shift_reg[ADDR_STRAP_LSB+:4] != strap_s |=> state_reg == ST_SKIP)
    else $error("mismatched address not skipped");
  skip_quiet_a: assert property (state_reg == ST_SKIP |-> !sda_oe)
    else $error("data driven after address mismatch");
  drive_on_fall_a: assert property ($rose(sda_oe) |-> $past(scl_fall))
    else $error("data line pulled outside clock low edge");
  step_up_a: assert property (state_reg == ST_STEP && scl_rise && sda_s &&
      !stop_cond && !start_cond && cnt_reg != BIT_ACK &&
      wiper_reg[idx_reg[3:2]] != WIPER_MAX |=>
      wiper_reg[idx_reg[3:2]] == $past(wiper_reg[idx_reg[3:2]]) + 8'h01)
    else $error("step up did not add one tap");
  step_sat_a: assert property (state_reg == ST_STEP && scl_rise && !sda_s &&
      wiper_reg[idx_reg[3:2]] == WIPER_MIN |=> wiper_reg[idx_reg[3:2]] == WIPER_MIN)
    else $error("step down wrapped below low end");
  step_ack_a: assert property (state_reg == ST_STEP && scl_rise &&
      cnt_reg == BIT_ACK |=> $stable(wiper_reg))
    else $error("ack clock moved a wiper in step mode");

  step_mode_c: cover property (state_reg == ST_STEP && scl_rise);
  read_byte_c: cover property (state_reg == ST_READ ##[1:1000] state_reg == ST_WAIT);
  stored_wr_c: cover property (st_we);
  skip_c:      cover property (state_reg == ST_SKIP);
endmodule : dps_ctrl

//--- verif/dps_bus_master.sv
`timescale 1ns/1ps
// ============================================================
// Bus master model: owns the serial clock, pulls data low only
module dps_bus_master (
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  localparam realtime QTR = 16.0; // Quarter of the 64 ns clock period

  // Clock stands high and data is released between frames
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // Start or repeated start; data is released while the clock is low, then pulled low while it is high
  task automatic start_cond();
    #QTR sda_pull = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_pull = 1'b1;
    #QTR scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    #QTR sda_pull = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_pull = 1'b0;
    #QTR;
  endtask : stop_cond

  // One clock pulse; the level read back is the wired line
  task automatic bit_io(input logic b, output logic r);
    #QTR sda_pull = ~b;
    #QTR scl = 1'b1;
    #QTR r = sda;
    #QTR scl = 1'b0;
  endtask : bit_io

  // Address byte carries the straps of the wanted device
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = (r === 1'b0);
  endtask : write_byte

  // Single byte reads end with a not-acknowledge
  task automatic read_byte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(1'b1, r);
  endtask : read_byte
endmodule : dps_bus_master

//--- verif/testbench.sv
`timescale 1ns/1ps
// ============================================================
// Self-checking bench for the serial control block
module testbench;
  import dps_pkg::*;
  logic                              sys_clk;
  logic                              rstn;
  logic                              write_guard_n;
  logic [3:0]                        strap;
  logic                              scl;
  logic                              sda_pull;
  logic                              sda_out;
  logic                              sda_oe;
  logic                              sda;
  logic                              od_bad = 1'b0;
  logic [NUM_POTS-1:0][TAP_W-1:0]    wiper_position;
  logic [NUM_POTS-1:0][NUM_TAPS-1:0] tap_sel;
  int                                fail_count;
  int                                samples_checked;

  // Wired line with pull-up; either party may pull it low
  assign sda = ~(sda_pull | (sda_oe & ~sda_out));

  dps_ctrl u_dut (
    .sys_clk(sys_clk), .rstn(rstn), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .write_guard_n(write_guard_n), .addr_strap_bit0(strap[0]),
    .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]), .addr_strap_bit3(strap[3]),
    .wiper_position(wiper_position), .tap_sel(tap_sel)
  );
  dps_bus_master u_master (.sda(sda), .scl(scl), .sda_pull(sda_pull));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Sticky flag: a driven high would break the shared line
  always @(posedge sys_clk) begin
    if (sda_oe === 1'b1 && sda_out !== 1'b0) od_bad <= 1'b1;
  end

  // ============================================================
  // Compare, report and verdict
  task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  // ============================================================
  // Bus helpers: address and instruction, then per-op tail
  task automatic cmd(input logic [3:0] to, input logic [3:0] op, input logic [1:0] pot,
                     input logic [1:0] slot, output logic [1:0] acks);
    u_master.start_cond();
    u_master.write_byte({DEV_TYPE, to, 1'b0}, acks[1]);
    u_master.write_byte({op, pot, slot}, acks[0]);
  endtask : cmd

  task automatic wr(input logic [3:0] op, input logic [1:0] p, input logic [1:0] s,
                    input logic [7:0] d);
    logic [1:0] a;
    logic       k;
    cmd(strap, op, p, s, a);
    check("cmd ack", a, 2'b11);
    if (op == OP_WR_WIPER || op == OP_WR_STORED) begin
      u_master.write_byte(d, k);
      check("data ack", k, 1'b1);
    end
    u_master.stop_cond();
  endtask : wr

  task automatic rd(input logic [3:0] op, input logic [1:0] p, input logic [1:0] s,
                    input logic [7:0] exp);
    logic [1:0] a;
    logic [7:0] d;
    cmd(strap, op, p, s, a);
    check("cmd ack", a, 2'b11);
    u_master.read_byte(d);
    u_master.stop_cond();
    check("read data", d, exp);
  endtask : rd

  // ============================================================
  // Scenarios
  task automatic t_wiper(); // Both end taps and two inner values
    for (int p = 0; p < 4; p++) wr(OP_WR_WIPER, 2'(p), 2'h0, 8'(p * 8'h55));
    for (int p = 0; p < 4; p++) begin
      rd(OP_RD_WIPER, 2'(p), 2'h0, 8'(p * 8'h55));
      check("wiper", wiper_position[p], 8'(p * 8'h55));
      check("tap", tap_sel[p], 256'(1) << (p * 8'h55));
    end
    $display("test wiper done");
  endtask : t_wiper

  task automatic t_stored();
    for (int i = 0; i < 16; i++) wr(OP_WR_STORED, 2'(i / 4), 2'(i % 4), 8'(8'h30 + i));
    for (int i = 0; i < 16; i++) begin
      rd(OP_RD_STORED, 2'(i / 4), 2'(i % 4), 8'(8'h30 + i));
    end
    $display("test stored done");
  endtask : t_stored

  task automatic t_copy();
    wr(OP_WR_WIPER, 2'h2, 2'h0, 8'h3C);
    wr(OP_SAVE, 2'h2, 2'h3, 8'h00);
    rd(OP_RD_STORED, 2'h2, 2'h3, 8'h3C);
    rd(OP_RD_STORED, 2'h1, 2'h3, 8'h37);
    wr(OP_RECALL, 2'h2, 2'h1, 8'h00);
    check("recall", wiper_position[2], 8'h39);
    $display("test copy done");
  endtask : t_copy

  task automatic t_guard(); // Guarded writes are acked but dropped
    @(negedge sys_clk) write_guard_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    wr(OP_WR_STORED, 2'h0, 2'h1, 8'hEE);
    wr(OP_SAVE, 2'h3, 2'h2, 8'h00);
    rd(OP_RD_STORED, 2'h0, 2'h1, 8'h31);
    rd(OP_RD_STORED, 2'h3, 2'h2, 8'h3E);
    wr(OP_WR_WIPER, 2'h0, 2'h0, 8'h77);
    check("guarded wiper", wiper_position[0], 8'h77);
    @(negedge sys_clk) write_guard_n = 1'b1;
    $display("test guard done");
  endtask : t_guard

  task automatic t_addr(); // Straps moved, old address must be ignored
    logic [1:0] a;
    logic       k;
    @(negedge sys_clk) strap = 4'b1010;
    repeat (4) @(negedge sys_clk);
    cmd(4'b0101, OP_WR_WIPER, 2'h0, 2'h0, a);
    u_master.write_byte(8'h11, k);
    u_master.stop_cond();
    check("foreign acks", {a, k}, 3'b000);
    check("foreign wiper", wiper_position[0], 8'h77);
    wr(OP_WR_WIPER, 2'h0, 2'h0, 8'h12);
    check("own wiper", wiper_position[0], 8'h12);
    // Unknown opcode: address acked, instruction refused, nothing changes
    cmd(strap, 4'h0, 2'h0, 2'h0, a);
    u_master.stop_cond();
    check("unknown op acks", a, 2'b10);
    check("unknown op wiper", wiper_position[0], 8'h12);
    $display("test address done");
  endtask : t_addr

  task automatic t_step(); // Each clock steps; ends must saturate
    logic [7:0] start_v[2] = '{8'hFD, 8'h02};
    logic [3:0] bits[2]    = '{4'b1110, 4'b0001};
    logic [7:0] exp[2][4]  = '{'{8'hFE, 8'hFF, 8'hFF, 8'hFE}, '{8'h01, 8'h00, 8'h00, 8'h01}};
    logic [1:0] a;
    logic       r;
    for (int j = 0; j < 2; j++) begin
      wr(OP_WR_WIPER, 2'h1, 2'h0, start_v[j]);
      cmd(strap, OP_STEP, 2'h1, 2'h0, a);
      check("step ack", a, 2'b11);
      for (int n = 0; n < 4; n++) begin
        u_master.bit_io(bits[j][3 - n], r);
        repeat (3) @(negedge sys_clk);
        check("step", wiper_position[1], exp[j][n]);
      end
      u_master.stop_cond();
    end
    $display("test step done");
  endtask : t_step

  task automatic t_boot(); // Second reset reloads slot 0 of each pot
    @(negedge sys_clk) rstn = 1'b0;
    repeat (4) @(negedge sys_clk);
    check("reset wiper", wiper_position[3], 8'h00);
    rstn = 1'b1;
    repeat (6) @(negedge sys_clk);
    for (int p = 0; p < 4; p++) check("boot", wiper_position[p], 8'(8'h30 + 4 * p));
    check("open drain", od_bad, 1'b0);
    $display("test boot done");
  endtask : t_boot

  // ============================================================
  // Main sequence
  initial begin
    fail_count      = 0;
    samples_checked = 0;
    rstn            = 1'b0;
    write_guard_n   = 1'b1;
    strap           = 4'b0101;
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (6) @(negedge sys_clk);
    for (int p = 0; p < 4; p++) check("erased", wiper_position[p], STORED_ERASED);
    t_wiper();
    t_stored();
    t_copy();
    t_guard();
    t_addr();
    t_step();
    t_boot();
    print_verdict();
  end

  // Run needs about 103 us; a hang is cut off at 80k clocks
  initial begin
    #400_000;
    fail_count++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule : testbench
